// ---- src/gst_pkg.sv ----
// package for the gated sixteen-bit timer: register map, field positions, reset values
// assumes an axi4-lite slave with 32-bit data, one register per aligned word
package gst_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_TIMER_CONTROL = 8'h10;
   localparam logic [7:0] OFF_COUNT_LOW = 8'h14;
   localparam logic [7:0] OFF_COUNT_HIGH = 8'h18;
   localparam logic [7:0] OFF_PERIPHERAL_FLAG = 8'h1c;
   localparam logic [7:0] OFF_PERIPHERAL_ENABLE = 8'h20;
   localparam logic [7:0] OFF_IRQ_CONTROL = 8'h24;
   localparam logic [7:0] OFF_PORT_STATUS = 8'h28;
   localparam logic [7:0] OFF_SYSTEM_CONFIG = 8'h2c;
   // control, flag, enable and irq field positions
   localparam int CTL_RUN = 0;
   localparam int CTL_SRC = 1;
   localparam int CTL_SYNC_BYP = 2;
   localparam int CTL_OSC_EN = 3;
   localparam int CTL_PS_LO = 4;
   localparam int CTL_GATE_EN = 6;
   localparam int FLAG_OVF = 0;
   localparam int IE_OVF = 0;
   localparam int IRQ_PERIPH = 6;
   localparam int IRQ_GLOBAL = 7;
   // reset values and count maximum
   localparam logic [6:0] CONTROL_RESET = 7'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   // instruction cycle is the system clock divided by four
   localparam logic [1:0] INSN_DIV_LAST = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic gate_enable;
      logic [1:0] prescale_select;
      logic lp_osc_enable;
      logic sync_bypass;
      logic clock_source_select;
      logic timer_run;
   } gst_control_t;

   typedef enum logic [1:0] {
      EDGE_ARM = 2'b00,
      EDGE_LOW = 2'b01,
      EDGE_HIGH = 2'b10
   } gst_edge_t;
endpackage : gst_pkg

// ---- src/gst_timer.sv ----
// gated sixteen-bit timer/counter with prescaler, overflow flag and register slave
// assumes one 100 MHz clock; ext_clock_in and gate_in_n are asynchronous pins
//
// Operation
// - sixteen-bit count wraps from ffff to zero
// - every rollover sets overflow flag bit zero
// - irq needs overflow, peripheral and global enables
// - timer mode counts every instruction cycle
// - source bit one selects external or fosc/4
// - counter mode counts external rising edges
// - falling edge needed before first counted rise
// - gate enable lets run only while gate low
// - gating applies in timer and counter modes
// - prescale field divides by one, two, four, eight
// - prescaler hidden; cleared by count byte writes
// - sync bypass bit only matters for external clock
// - unsynchronised counter runs in sleep, wakes core
// - count reads valid while running from external clock
// - oscillator enable acts only on internal oscillator
// - oscillator on forces pin directions one, pins zero
// - control bit zero runs or stops timer
// - control bit seven reads zero; fields reset zero
`timescale 1ns/1ps
module gst_timer
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // timer pins and system status
   input wire logic ext_clock_in,
   input wire logic gate_in_n,
   input wire logic sleep_mode,
   // outputs
   output logic irq,
   output logic wake,
   output logic pin5_direction,
   output logic pin4_direction
);
   gst_pkg::gst_control_t ctl_reg;
   logic [15:0] count_reg;
   logic [2:0] presc_reg;
   logic [1:0] insn_div_reg;
   logic ovf_flag_reg;
   logic ovf_ie_reg;
   logic periph_ie_reg;
   logic global_ie_reg;
   logic int_osc_reg;
   logic [5:0] port_in_reg;
   logic [5:0] port_dir_reg;
   logic ext_s1_reg, ext_s2_reg, ext_s3_reg;
   logic gate_s1_reg, gate_s2_reg;
   gst_pkg::gst_edge_t edge_reg, edge_next;
   logic aw_hold_reg, w_hold_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;

   // instruction cycle enable, fosc/4
   wire insn_tick = (insn_div_reg == gst_pkg::INSN_DIV_LAST);
   // rising edge on synchronised external clock, ahead of the falling-edge guard
   wire ext_rise = ext_s2_reg & ~ext_s3_reg;
   wire ext_fall = ~ext_s2_reg & ext_s3_reg;
   // the unsynchronised path still needs a sampled edge in this single-clock design;
   // bypass only keeps counting in sleep; the falling-edge guard still applies
   wire ext_tick = ext_rise && (edge_reg == gst_pkg::EDGE_LOW);
   wire src_tick = ctl_reg.clock_source_select ? ext_tick : insn_tick;
   wire gate_open = ~ctl_reg.gate_enable | ~gate_s2_reg;
   // sleep stops the synchronised and internal modes only
   wire sleep_ok = ~sleep_mode | (ctl_reg.clock_source_select & ctl_reg.sync_bypass);
   wire run = ctl_reg.timer_run & gate_open & sleep_ok;
   // last prescaler count for the selected division; three bits reach divide by eight
   wire [2:0] presc_last = 3'((1 << ctl_reg.prescale_select) - 1);
   wire presc_tick = run && src_tick && (presc_reg == presc_last);
   wire rollover = presc_tick && (count_reg == gst_pkg::COUNT_MAX);
   wire osc_active = ctl_reg.lp_osc_enable & int_osc_reg;

   // write decode: both channels held, response slot free
   wire wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
   wire wr_ctl = wr_go && aw_addr_reg == gst_pkg::OFF_TIMER_CONTROL && w_strb_reg[0];
   wire wr_lo = wr_go && aw_addr_reg == gst_pkg::OFF_COUNT_LOW && w_strb_reg[0];
   wire wr_hi = wr_go && aw_addr_reg == gst_pkg::OFF_COUNT_HIGH && w_strb_reg[0];
   wire wr_flag = wr_go && aw_addr_reg == gst_pkg::OFF_PERIPHERAL_FLAG && w_strb_reg[0];
   wire wr_pie = wr_go && aw_addr_reg == gst_pkg::OFF_PERIPHERAL_ENABLE && w_strb_reg[0];
   wire wr_irq = wr_go && aw_addr_reg == gst_pkg::OFF_IRQ_CONTROL && w_strb_reg[0];
   wire wr_port = wr_go && aw_addr_reg == gst_pkg::OFF_PORT_STATUS && w_strb_reg[0];
   wire wr_sys = wr_go && aw_addr_reg == gst_pkg::OFF_SYSTEM_CONFIG && w_strb_reg[0];
   // unmapped addresses are answered with an error and change nothing
   wire wr_hit = aw_addr_reg inside {gst_pkg::OFF_TIMER_CONTROL, gst_pkg::OFF_COUNT_LOW,
      gst_pkg::OFF_COUNT_HIGH, gst_pkg::OFF_PERIPHERAL_FLAG, gst_pkg::OFF_PERIPHERAL_ENABLE,
      gst_pkg::OFF_IRQ_CONTROL, gst_pkg::OFF_PORT_STATUS, gst_pkg::OFF_SYSTEM_CONFIG};
   wire [7:0] wbyte = w_data_reg[7:0];

   // port view: oscillator pins forced when the oscillator owns them
   wire [5:0] dir_view = osc_active ? (port_dir_reg | 6'h30) : port_dir_reg;
   wire [5:0] pin_view = osc_active ? (port_in_reg & 6'h0f) : port_in_reg;

   // read mux; the count is a plain register in this clock domain, so reads are coherent
   logic [31:0] rd_word;
   logic rd_hit;
   always_comb
   begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         gst_pkg::OFF_TIMER_CONTROL: rd_word = {25'h0, ctl_reg};
         gst_pkg::OFF_COUNT_LOW: rd_word = {24'h0, count_reg[7:0]};
         gst_pkg::OFF_COUNT_HIGH: rd_word = {24'h0, count_reg[15:8]};
         gst_pkg::OFF_PERIPHERAL_FLAG: rd_word = {31'h0, ovf_flag_reg};
         gst_pkg::OFF_PERIPHERAL_ENABLE: rd_word = {31'h0, ovf_ie_reg};
         gst_pkg::OFF_IRQ_CONTROL: rd_word = {24'h0, global_ie_reg, periph_ie_reg, 6'h0};
         gst_pkg::OFF_PORT_STATUS: rd_word = {18'h0, dir_view, 2'h0, pin_view};
         gst_pkg::OFF_SYSTEM_CONFIG: rd_word = {31'h0, int_osc_reg};
         default: rd_hit = 1'b0;
      endcase
   end

   // falling-edge guard for the external input
   always_comb
   begin
      edge_next = edge_reg;
      case (edge_reg)
         gst_pkg::EDGE_ARM: if (ext_fall) edge_next = gst_pkg::EDGE_LOW;
         gst_pkg::EDGE_LOW: if (ext_rise) edge_next = gst_pkg::EDGE_HIGH;
         gst_pkg::EDGE_HIGH: if (ext_fall) edge_next = gst_pkg::EDGE_LOW;
         default: edge_next = gst_pkg::EDGE_ARM;
      endcase
      if (!ctl_reg.clock_source_select)
         edge_next = gst_pkg::EDGE_ARM;
   end

   // pin synchronisers, two flops before use
   always_ff @(posedge aclk)
   begin
      ext_s1_reg <= ext_clock_in;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
      gate_s1_reg <= gate_in_n;
      gate_s2_reg <= gate_s1_reg;
   end

   // counting datapath
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         insn_div_reg <= 2'h0;
         presc_reg <= 3'h0;
         count_reg <= gst_pkg::COUNT_RESET;
         edge_reg <= gst_pkg::EDGE_ARM;
      end
      else
      begin
         insn_div_reg <= insn_div_reg + 2'h1;
         edge_reg <= edge_next;
         if (wr_lo || wr_hi)
            presc_reg <= 3'h0;
         else if (run && src_tick)
            presc_reg <= presc_tick ? 3'h0 : presc_reg + 3'h1;
         // a software write wins over a coinciding increment
         if (wr_lo)
            count_reg[7:0] <= wbyte;
         else if (wr_hi)
            count_reg[15:8] <= wbyte;
         else if (presc_tick)
            count_reg <= count_reg + 16'h0001;
      end
   end

   // control and interrupt registers; a rollover wins over a clear in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctl_reg <= gst_pkg::CONTROL_RESET;
         ovf_flag_reg <= 1'b0;
         ovf_ie_reg <= 1'b0;
         periph_ie_reg <= 1'b0;
         global_ie_reg <= 1'b0;
         int_osc_reg <= 1'b0;
         port_dir_reg <= 6'h3f;
         port_in_reg <= 6'h00;
      end
      else
      begin
         if (wr_ctl)
            ctl_reg <= wbyte[6:0];
         if (rollover)
            ovf_flag_reg <= 1'b1;
         else if (wr_flag)
            ovf_flag_reg <= wbyte[gst_pkg::FLAG_OVF];
         if (wr_pie)
            ovf_ie_reg <= wbyte[gst_pkg::IE_OVF];
         if (wr_irq)
         begin
            periph_ie_reg <= wbyte[gst_pkg::IRQ_PERIPH];
            global_ie_reg <= wbyte[gst_pkg::IRQ_GLOBAL];
         end
         if (wr_sys)
            int_osc_reg <= wbyte[0];
         if (wr_port)
            port_dir_reg <= w_data_reg[13:8];
         // pin view takes the synchronised pins, never the raw ones
         port_in_reg <= {gate_s2_reg, ext_s2_reg, 4'h0};
      end
   end

   // outputs from flops
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq <= 1'b0;
         wake <= 1'b0;
         pin5_direction <= 1'b1;
         pin4_direction <= 1'b1;
      end
      else
      begin
         irq <= ovf_flag_reg & ovf_ie_reg & periph_ie_reg & global_ie_reg;
         wake <= ovf_flag_reg & ovf_ie_reg & periph_ie_reg;
         pin5_direction <= dir_view[5];
         pin4_direction <= dir_view[4];
      end
   end

   // axi write channels, taken in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= gst_pkg::RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_hold_reg && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? gst_pkg::RESP_OKAY : gst_pkg::RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // axi read channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= gst_pkg::RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? gst_pkg::RESP_OKAY : gst_pkg::RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // counting checks; a count load in the same cycle is left out, since a write beats an increment
   a_count_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
      rollover && !wr_lo && !wr_hi |=> count_reg == 16'h0000)
      else $error("count did not wrap");
   a_stop_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      !ctl_reg.timer_run && !wr_lo && !wr_hi |=> $stable(count_reg))
      else $error("count moved while off");
   a_gate_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      ctl_reg.gate_enable && gate_s2_reg && !wr_lo && !wr_hi |=> $stable(count_reg))
      else $error("count moved with gate closed");
   a_sleep_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      sleep_mode && !(ctl_reg.clock_source_select && ctl_reg.sync_bypass) && !wr_lo && !wr_hi
      |=> $stable(count_reg)) else $error("count moved in sleep");

   // edge guard watched on the count itself, so a broken tick path cannot hide; rate watched on presc_tick
   // the rate check relies on software stopping the timer before switching the source
   a_fall_first: assert property (@(posedge aclk) disable iff (!aresetn)
      ctl_reg.clock_source_select && edge_reg == gst_pkg::EDGE_ARM && !wr_lo && !wr_hi
      |=> $stable(count_reg)) else $error("rise counted before fall");
   a_timer_rate: assert property (@(posedge aclk) disable iff (!aresetn)
      presc_tick && !ctl_reg.clock_source_select |=> (!presc_tick) [*3])
      else $error("timer off instruction cycle");

   // prescaler and overflow flag
   a_presc_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_lo || wr_hi) |=> presc_reg == 3'h0)
      else $error("prescaler not cleared");
   a_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
      rollover |=> ovf_flag_reg)
      else $error("rollover did not set flag");
   a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
      ovf_flag_reg && !wr_flag |=> ovf_flag_reg)
      else $error("flag cleared by hardware");
   a_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_flag && !wbyte[gst_pkg::FLAG_OVF] && !rollover |=> !ovf_flag_reg)
      else $error("flag clear lost");

   // interrupt, wake, pins and control read-back
   a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      irq |-> $past(ovf_flag_reg & ovf_ie_reg & periph_ie_reg & global_ie_reg))
      else $error("irq without all enables");
   a_wake_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      wake |-> $past(ovf_flag_reg & ovf_ie_reg & periph_ie_reg))
      else $error("wake without enables");
   a_osc_pins: assert property (@(posedge aclk) disable iff (!aresetn)
      osc_active |-> dir_view[5:4] == 2'b11 && pin_view[5:4] == 2'b00)
      else $error("osc pins not forced");
   a_ctl_read: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && s_axi_araddr == gst_pkg::OFF_TIMER_CONTROL
      |=> s_axi_rdata[31:7] == 25'h0) else $error("control read shows unused bits");

   // main scenarios: rollover, interrupt, external count, counting asleep, gate shut
   // a cover that never hits points at a scenario the bench no longer reaches
   c_rollover: cover property (@(posedge aclk) disable iff (!aresetn) rollover);
   c_irq: cover property (@(posedge aclk) disable iff (!aresetn) irq);
   c_ext_count: cover property (@(posedge aclk) disable iff (!aresetn) presc_tick && ctl_reg.clock_source_select);
   c_sleep_count: cover property (@(posedge aclk) disable iff (!aresetn) presc_tick && sleep_mode);
   c_gate_shut: cover property (@(posedge aclk) disable iff (!aresetn) ctl_reg.timer_run && !gate_open);
endmodule : gst_timer

// ---- bench/gst_ext_clock_model.sv ----
// external count clock source standing in front of the timer's clock pin
// assumes the bench calls its tasks from the aclk domain; the pin idles low between bursts
`timescale 1ns/1ps
module gst_ext_clock_model
(
   // pacing clock
   input wire logic aclk,
   // driven clock pin
   output logic ext_clock_in
);
   int half = 5;

   initial ext_clock_in = 1'b0;

   // a lone rise with no fall before it; the counter must let it pass uncounted
   task automatic rise_only();
      @(posedge aclk);
      ext_clock_in <= 1'b1;
      repeat (half) @(posedge aclk);
   endtask : rise_only

   // n periods, fall first; half periods long enough for the synchroniser to see each level
   task automatic pulses(input int n);
      for (int i = 0; i < n; i++)
      begin
         ext_clock_in <= 1'b0;
         repeat (half) @(posedge aclk);
         ext_clock_in <= 1'b1;
         repeat (half) @(posedge aclk);
      end
      ext_clock_in <= 1'b0;
      @(posedge aclk);
   endtask : pulses
endmodule : gst_ext_clock_model

// ---- bench/tb_top.sv ----
// self-checking bench for the gated sixteen-bit timer, driven over axi4-lite
// assumes a 100 MHz aclk and the register map of the design package
`timescale 1ns/1ps
module tb_top;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic awready, wready, bvalid, arready, rvalid, irq, wake, dir5, dir4, ext_clk;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, rd;
   logic gate_n = 1'b1, sleep = 1'b0;
   int fail_count = 0, check_count = 0, cycles = 0;

   gst_timer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_clock_in(ext_clk),
      .gate_in_n(gate_n), .sleep_mode(sleep), .irq(irq), .wake(wake), .pin5_direction(dir5),
      .pin4_direction(dir4));
   gst_ext_clock_model ext (.aclk(aclk), .ext_clock_in(ext_clk));

   always #5 aclk = ~aclk;

   // hang guard: the whole run needs well under this many cycles
   always @(posedge aclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 60000)
      begin
         fail_count++;
         final_report();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic final_report();
      if (fail_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report

   // both channels offered together, each dropped when taken; bready held until bvalid
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp_resp = 2'h0);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid)
         begin
            bready <= 1'b0;
            check(bresp, exp_resp);
            break;
         end
      end
      // one edge passes, so the next call never raises bready in the step that lowered it
      @(posedge aclk);
   endtask : wr

   task automatic rdreg(input logic [7:0] a, input logic [1:0] exp_resp = 2'h0);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid)
         begin
            rready <= 1'b0;
            rd = rdata;
            check(rresp, exp_resp);
            break;
         end
      end
      // one edge passes, so the next call never raises rready in the step that lowered it
      @(posedge aclk);
   endtask : rdreg

   // stop and zero the count, as software must before touching it
   task automatic clear_count();
      wr(gst_pkg::OFF_TIMER_CONTROL, 32'h0);
      wr(gst_pkg::OFF_COUNT_HIGH, 32'h0);
      wr(gst_pkg::OFF_COUNT_LOW, 32'h0);
   endtask : clear_count

   task automatic test_regs();
      check({dir5, dir4, irq, wake}, 32'hc);
      rdreg(gst_pkg::OFF_TIMER_CONTROL);
      check(rd, 32'h0);
      rdreg(gst_pkg::OFF_COUNT_LOW);
      check(rd, 32'h0);
      wr(gst_pkg::OFF_TIMER_CONTROL, 32'hfe);
      rdreg(gst_pkg::OFF_TIMER_CONTROL);
      check(rd, 32'h7e);
      wr(8'h40, 32'h1, 2'h2);
      rdreg(8'h40, 2'h2);
      wr(gst_pkg::OFF_TIMER_CONTROL, 32'h0);
   endtask : test_regs

   // each prescale code: count tracks elapsed cycles over four times the division
   task automatic test_prescale();
      int t0, div;
      for (int p = 0; p < 4; p++)
      begin
         div = 1 << p;
         clear_count();
         wr(gst_pkg::OFF_TIMER_CONTROL, 32'h1 | (p << 4));
         t0 = cycles;
         repeat (64 * div) @(posedge aclk);
         wr(gst_pkg::OFF_TIMER_CONTROL, 32'h0);
         t0 = (cycles - t0) / (4 * div);
         rdreg(gst_pkg::OFF_COUNT_LOW);
         check(32'(rd >= t0 - 1 && rd <= t0 + 1), 32'h1);
      end
   endtask : test_prescale

   task automatic test_rollover();
      clear_count();
      wr(gst_pkg::OFF_COUNT_HIGH, 32'hff);
      wr(gst_pkg::OFF_COUNT_LOW, 32'hf0);
      wr(gst_pkg::OFF_PERIPHERAL_FLAG, 32'h0);
      wr(gst_pkg::OFF_PERIPHERAL_ENABLE, 32'h1);
      wr(gst_pkg::OFF_IRQ_CONTROL, 32'h40);
      wr(gst_pkg::OFF_TIMER_CONTROL, 32'h1);
      repeat (120) @(posedge aclk);
      check({irq, wake}, 32'h1);
      wr(gst_pkg::OFF_IRQ_CONTROL, 32'hc0);
      repeat (3) @(posedge aclk);
      check(irq, 32'h1);
      wr(gst_pkg::OFF_TIMER_CONTROL, 32'h0);
      rdreg(gst_pkg::OFF_COUNT_HIGH);
      check(rd, 32'h0);
      repeat (50) @(posedge aclk);
      rdreg(gst_pkg::OFF_PERIPHERAL_FLAG);
      check(rd[0], 32'h1);
      wr(gst_pkg::OFF_PERIPHERAL_FLAG, 32'h0);
      repeat (3) @(posedge aclk);
      check({irq, wake}, 32'h0);
      wr(gst_pkg::OFF_IRQ_CONTROL, 32'h0);
   endtask : test_rollover

   task automatic test_gate();
      clear_count();
      gate_n <= 1'b1;
      wr(gst_pkg::OFF_TIMER_CONTROL, 32'h41);
      repeat (100) @(posedge aclk);
      rdreg(gst_pkg::OFF_COUNT_LOW);
      check(rd, 32'h0);
      gate_n <= 1'b0;
      repeat (100) @(posedge aclk);
      rdreg(gst_pkg::OFF_COUNT_LOW);
      check(32'(rd != 0), 32'h1);
      gate_n <= 1'b1;
   endtask : test_gate

   // external source: sync and bypass, awake and asleep, and one gated run
   task automatic test_external();
      logic [7:0] ctl [5] = '{8'h03, 8'h07, 8'h03, 8'h07, 8'h43};
      logic slp [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
      logic [31:0] exp [5] = '{32'h5, 32'h5, 32'h0, 32'h5, 32'h0};
      for (int i = 0; i < 5; i++)
      begin
         clear_count();
         sleep <= slp[i];
         wr(gst_pkg::OFF_TIMER_CONTROL, {24'h0, ctl[i]});
         ext.rise_only();
         ext.pulses(5);
         repeat (10) @(posedge aclk);
         sleep <= 1'b0;
         wr(gst_pkg::OFF_TIMER_CONTROL, 32'h0);
         rdreg(gst_pkg::OFF_COUNT_LOW);
         check(rd, exp[i]);
      end
   endtask : test_external

   task automatic test_osc();
      for (int s = 0; s < 2; s++)
      begin
         wr(gst_pkg::OFF_SYSTEM_CONFIG, 32'(s));
         wr(gst_pkg::OFF_PORT_STATUS, 32'h0);
         wr(gst_pkg::OFF_TIMER_CONTROL, 32'h08);
         repeat (3) @(posedge aclk);
         check({dir5, dir4}, s ? 32'h3 : 32'h0);
         rdreg(gst_pkg::OFF_PORT_STATUS);
         check({rd[13:12], rd[5:4]}, s ? 32'hc : 32'h2);
         wr(gst_pkg::OFF_TIMER_CONTROL, 32'h0);
      end
   endtask : test_osc

   initial
   begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      test_regs();
      test_prescale();
      test_rollover();
      test_gate();
      test_external();
      test_osc();
      final_report();
   end
endmodule : tb_top
